// file: hw/bchr_pkg.sv
package bchr_pkg;
   // ------------------------------------------------------------
   // register offsets (byte addresses in configuration space)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_BURST_TIME_SLICE = 8'h0d;
   localparam logic [7:0] OFS_HEADER_LAYOUT = 8'h0e;
   localparam logic [7:0] OFS_APERTURE_BASE = 8'h10;
   localparam logic [7:0] OFS_CAPABILITY_POINTER = 8'h34;
   // ------------------------------------------------------------
   // reset values and fixed contents
   // ------------------------------------------------------------
   localparam logic [7:0] RST_BURST_TIME_SLICE = 8'h00;
   localparam logic [7:0] VAL_HEADER_LAYOUT = 8'h00;
   localparam logic [31:0] RST_APERTURE_BASE = 32'h00000008;
   localparam logic [7:0] VAL_CAPABILITY_POINTER = 8'ha0;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int SLICE_LSB = 3;
   localparam int AP_UPPER_LSB = 28;
   localparam int AP_SEL_LSB = 22;
   localparam int AP_SEL_W = 6;
endpackage

// file: hw/bchr_slice_timer.sv
`timescale 1ns/100ps
// counts pci clocks of the granted slice while mastering the bus
module bchr_slice_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] slice_val,
   input wire logic master_active,
   output logic expired
);
   logic [7:0] count_r;
   logic [7:0] limit;
   logic [8:0] next_count;

   // low three bits of the slice never count
   assign limit = {slice_val[7:bchr_pkg::SLICE_LSB], 3'h0}; // R01 R03
   // one bit wider so the saturated count cannot wrap and drop expiry
   assign next_count = {1'b0, count_r} + 9'h001;

   // count while mastering; reload when the bus is not ours
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= 8'h00;
      end else if (!master_active) begin
         count_r <= 8'h00;
      end else if (count_r != 8'hff) begin
         count_r <= count_r + 8'h01; // R02
      end
   end

   // zero slice disables the limit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         expired <= 1'b0;
      end else begin
         expired <= master_active && (limit != 8'h00) && (next_count >= {1'b0, limit}); // R03
      end
   end
endmodule // bchr_slice_timer

// file: hw/bchr_regs.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Summary of operation
// R01: slice count ignores its three low bits
// R02: count slice; at expiry, no grant and data phase done, release
// R03: slice bits map to clocks; zero disables
// R04: header layout reads zero, ignores writes
// R05: aperture upper bits writable, reset zero
// R06: bits 27:22 writable per size select
// R07: clear select bit forces base bit zero
// R08: aperture sizes from 4 MB to 256 MB
// R09: capability pointer read-only, returns a0h
// R10: base bits 21:0 read reset pattern
// ------------------------------------------------------------
module bchr_regs (
   input wire logic clk,
   input wire logic rst_n,
   // configuration access, same clock domain
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   // size select from the back-end register
   input wire logic [5:0] aperture_size_select,
   // bus master state
   input wire logic master_active,
   input wire logic grant,
   input wire logic data_phase_done,
   output logic bus_release,
   output logic [7:0] burst_time_slice,
   output logic [31:0] aperture_base
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [7:0] slice_r;
   logic [3:0] ap_upper_r;
   logic [5:0] ap_sel_r;
   logic [31:0] ap_view;
   logic [5:0] ap_masked;
   logic slice_expired;
   logic [7:0] word_base;
   logic [31:0] rd_word;

   // dword-aligned address of the access
   assign word_base = {cfg_addr[7:2], 2'h0};

   // burst time slice lives in byte 1 of dword 0ch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slice_r <= bchr_pkg::RST_BURST_TIME_SLICE; // R03
      end else if (cfg_wr && word_base == {bchr_pkg::OFS_BURST_TIME_SLICE[7:2], 2'h0} && cfg_be[1]) begin
         slice_r <= cfg_wdata[15:8];
      end
   end

   // upper aperture bits always writable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ap_upper_r <= bchr_pkg::RST_APERTURE_BASE[31:28]; // R05
      end else if (cfg_wr && word_base == bchr_pkg::OFS_APERTURE_BASE && cfg_be[3]) begin
         ap_upper_r <= cfg_wdata[31:28]; // R05
      end
   end

   // ------------------------------------------------------------
   // selectable aperture base bits
   // ------------------------------------------------------------
   // one cell per selectable bit: stored masked, gated again on read
   // each cell follows the byte enable of the byte that holds it
   for (genvar gi = 0; gi < bchr_pkg::AP_SEL_W; gi++) begin : g_sel
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            ap_sel_r[gi] <= bchr_pkg::RST_APERTURE_BASE[bchr_pkg::AP_SEL_LSB + gi];
         end else if (cfg_wr && word_base == bchr_pkg::OFS_APERTURE_BASE
                      && cfg_be[(bchr_pkg::AP_SEL_LSB + gi) / 8]) begin
            ap_sel_r[gi] <= cfg_wdata[bchr_pkg::AP_SEL_LSB + gi] & aperture_size_select[gi]; // R06
         end
      end
   end

   // mask again on read so a later select change hides old bits
   assign ap_masked = ap_sel_r & aperture_size_select; // R07 R08
   // low bits fixed at their reset pattern
   assign ap_view = {ap_upper_r, ap_masked, bchr_pkg::RST_APERTURE_BASE[21:0]}; // R10

   // read mux; header layout and unmapped bytes read zero
   always_comb begin
      rd_word = 32'h00000000;
      case (word_base)
         {bchr_pkg::OFS_BURST_TIME_SLICE[7:2], 2'h0}: begin
            rd_word = {8'h00, bchr_pkg::VAL_HEADER_LAYOUT, slice_r, 8'h00}; // R04
         end
         bchr_pkg::OFS_APERTURE_BASE: begin
            rd_word = ap_view;
         end
         bchr_pkg::OFS_CAPABILITY_POINTER: begin
            rd_word = {24'h000000, bchr_pkg::VAL_CAPABILITY_POINTER}; // R09
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   // registered read answer, one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata <= 32'h00000000;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rvalid <= cfg_rd;
         if (cfg_rd) begin
            cfg_rdata <= rd_word;
         end
      end
   end

   // mirrors of the steering registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         burst_time_slice <= bchr_pkg::RST_BURST_TIME_SLICE;
         aperture_base <= bchr_pkg::RST_APERTURE_BASE;
      end else begin
         burst_time_slice <= slice_r;
         aperture_base <= ap_view;
      end
   end

   // ------------------------------------------------------------
   // slice timer
   // ------------------------------------------------------------
   bchr_slice_timer u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .slice_val(slice_r),
      .master_active(master_active),
      .expired(slice_expired)
   );

   // release only after expiry, grant gone and data phase finished
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_release <= 1'b0;
      end else begin
         bus_release <= slice_expired && !grant && data_phase_done; // R02
      end
   end
endmodule // bchr_regs

// file: tb/bchr_regs_assertions.sv
`timescale 1ns/100ps
// watches the register bank at its ports only
module bchr_regs_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rvalid,
   input wire logic [5:0] aperture_size_select,
   input wire logic grant,
   input wire logic data_phase_done,
   input wire logic bus_release,
   input wire logic [7:0] burst_time_slice,
   input wire logic [31:0] aperture_base
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // dword-addressed strobes
   sequence s_rd(a); cfg_rd && cfg_addr[7:2] == a; endsequence
   sequence s_wr(a, b); cfg_wr && cfg_addr[7:2] == a && cfg_be[b]; endsequence
   property p_cap; s_rd(6'h0d) |=> cfg_rvalid && cfg_rdata[7:0] == 8'ha0; endproperty
   a_cap: assert property (p_cap) else $error("pointer read wrong");
   property p_hdr; s_rd(6'h03) |=> cfg_rvalid && cfg_rdata[23:16] == 8'h00; endproperty
   a_hdr: assert property (p_hdr) else $error("header byte not zero");
   property p_low; aperture_base[21:0] == 22'h8; endproperty
   a_low: assert property (p_low) else $error("base low bits changed");
   property p_sel; (aperture_base[27:22] & ~$past(aperture_size_select)) == 6'h0; endproperty
   a_sel: assert property (p_sel) else $error("deselected base bit set");
   // base and slice outputs are mirrors, one clock behind the storage
   property p_up; s_wr(6'h04, 3) |-> ##2 aperture_base[31:28] == $past(cfg_wdata[31:28], 2); endproperty
   a_up: assert property (p_up) else $error("base upper bits not written");
   property p_slc; s_wr(6'h03, 1) |-> ##2 burst_time_slice == $past(cfg_wdata[15:8], 2); endproperty
   a_slc: assert property (p_slc) else $error("slice not written");
   property p_rel; bus_release |-> $past(!grant && data_phase_done); endproperty
   a_rel: assert property (p_rel) else $error("release while granted");
   property p_off; (burst_time_slice[7:3] == 5'h0) [*3] |=> !bus_release; endproperty
   a_off: assert property (p_off) else $error("release with limit off");
endmodule // bchr_regs_chk
bind bchr_regs bchr_regs_chk u_chk (.*);

// file: tb/bchr_arb_model.sv
`timescale 1ns/100ps
// rival master: takes the grant back two clocks into our tenure
module bchr_arb_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic master_active,
   output logic grant,
   output logic data_phase_done
);
   logic [1:0] held_r;
   // saturating tenure count, cleared when we leave the bus
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) held_r <= 2'h0;
      else if (!master_active) held_r <= 2'h0;
      else if (held_r != 2'h3) held_r <= held_r + 2'h1;
   end
   assign grant = master_active && (held_r < 2'h2);
   // single-clock data phases, so every clock ends one
   assign data_phase_done = master_active;
endmodule // bchr_arb_model

// file: tb/bridge_config_header_regs_bench.sv
`timescale 1ns/100ps
module bridge_config_header_regs_bench;
   logic clk = 0, rst_n = 0, cfg_wr = 0, cfg_rd = 0, master_active = 0;
   logic grant, data_phase_done, bus_release, cfg_rvalid;
   logic [7:0] cfg_addr = 8'h00, burst_time_slice;
   logic [3:0] cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0, cfg_rdata, aperture_base;
   logic [5:0] aperture_size_select = 6'h3f;
   int err_total = 0, n_compared = 0, cyc = 0, n1, n2, n3;
   bchr_regs DUT (.*);
   bchr_arb_model u_arb (.*);
   always #4 clk = ~clk;
   // hang guard, far above the few hundred clocks the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         close_out;
      end
   end
   task automatic close_out;
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge clk);
      {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, d};
      @(negedge clk);
      cfg_wr = 0;
   endtask
   // answer is registered, so it stands at the following falling edge
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(negedge clk);
      {cfg_rd, cfg_addr} = {1'b1, a};
      @(negedge clk);
      cfg_rd = 0;
      chk("rvalid", 32'h1, {31'h0, cfg_rvalid});
      chk("rdata", e, cfg_rdata);
   endtask
   // clocks from taking the bus to release; 100 means never released
   task automatic run(input logic [7:0] s, output int n);
      wr(8'h0c, 4'h2, {16'h0, s, 8'h0});
      master_active = 1;
      for (n = 0; bus_release !== 1'b1 && n < 100; n++) @(negedge clk);
      master_active = 0;
      repeat (4) @(negedge clk);
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1;
      rd(8'h0c, 32'h0);
      rd(8'h10, 32'h8);
      rd(8'h34, 32'ha0);
      rd(8'h40, 32'h0);
      wr(8'h0c, 4'hf, '1);
      rd(8'h0c, 32'h0000ff00);
      wr(8'h34, 4'hf, '1);
      rd(8'h34, 32'ha0);
      $display("fixed registers done");
      // every aperture size from 4 MB up to 256 MB
      for (int i = 0; i < 7; i++) begin
         aperture_size_select = 6'h3f << i;
         wr(8'h10, 4'hf, '1);
         rd(8'h10, {4'hf, aperture_size_select, 22'h8});
      end
      wr(8'h10, 4'hf, 32'h0);
      @(negedge clk);
      chk("base", 32'h8, aperture_base);
      $display("aperture done");
      run(8'h10, n1);
      run(8'h18, n2);
      run(8'h1f, n3);
      chk("slice step", 32'd8, n2 - n1);
      chk("low bits", n2, n3);
      chk("slice mirror", 32'h1f, {24'h0, burst_time_slice});
      run(8'h00, n1);
      chk("limit off", 32'd100, n1);
      $display("slice timer done");
      close_out;
   end
endmodule // bridge_config_header_regs_bench
